// *** design/lgsd_top.sv ***
`timescale 1ns/100ps
`include "lgsd_params.svh"

module lgsd_top #(
    parameter int unsigned BLINK_CYCLES = `LGSD_BLINK_CYC  // Cycles per blink phase
) (
    input  wire logic                                     CLK,
    input  wire logic                                     SRST,
    input  wire logic                                     LINK_UP,
    input  wire logic                                     SPEED_100,
    input  wire logic                                     AN_BUSY,
    input  wire logic                                     FULL_DUPLEX,
    input  wire logic                                     ACTIVITY,
    input  wire lgsd_pkg::lgsd_mode_e [`LGSD_NPINS-1:0]   PIN_MODE,
    input  wire logic [`LGSD_NPINS-1:0]                   GPIO_DOUT,
    input  wire logic [`LGSD_NPINS-1:0]                   PIN_I,
    output logic [`LGSD_NPINS-1:0]                        PIN_O,
    output logic [`LGSD_NPINS-1:0]                        PIN_OE,
    output logic [`LGSD_NPINS-1:0]                        GPIO_DIN
);
    import lgsd_pkg::*;

    // Last count of a blink phase; phase lasts exactly BLINK_CYCLES
    localparam logic [`LGSD_CNT_W-1:0] BLINK_LAST = `LGSD_CNT_W'(BLINK_CYCLES - 1);

    lgsd_core_s c_q;  // Registered core state
    lgsd_core_s c_d;  // Next core state
    logic [`LGSD_NPINS-1:0] led_n;  // Indicator levels per pin
    logic phase_end;  // Blink phase expires this cycle

    assign phase_end = (c_q.cnt == BLINK_LAST);

    // Indicator levels and blink sequencer
    always_comb begin
        c_d = c_q;
        // Speed lit only once negotiation settled on 100Mb
        c_d.speed_n  = ~(LINK_UP & SPEED_100 & ~AN_BUSY);
        c_d.duplex_n = ~(LINK_UP & FULL_DUPLEX);
        case (c_q.st)
            LGSD_ST_STEADY: begin
                c_d.cnt = '0;
                if (ACTIVITY || c_q.pend) begin
                    c_d.st   = LGSD_ST_DARK;
                    c_d.pend = 1'b0;
                end
            end
            LGSD_ST_DARK: begin
                // Activity during the pulse is kept for the next round
                c_d.pend = c_q.pend | ACTIVITY;
                c_d.cnt  = c_q.cnt + 1'b1;
                if (phase_end) begin
                    c_d.st  = LGSD_ST_LIT;
                    c_d.cnt = '0;
                end
            end
            LGSD_ST_LIT: begin
                c_d.pend = c_q.pend | ACTIVITY;
                c_d.cnt  = c_q.cnt + 1'b1;
                if (phase_end) begin
                    c_d.cnt = '0;
                    if (c_q.pend || ACTIVITY) begin
                        c_d.st   = LGSD_ST_DARK;
                        c_d.pend = 1'b0;
                    end else begin
                        c_d.st = LGSD_ST_STEADY;
                    end
                end
            end
            default: begin
                // Illegal code: recover to steady
                c_d.st   = LGSD_ST_STEADY;
                c_d.cnt  = '0;
                c_d.pend = 1'b0;
            end
        endcase
        // Without a link nothing blinks and no event is remembered
        if (!LINK_UP) begin
            c_d.st   = LGSD_ST_STEADY;
            c_d.cnt  = '0;
            c_d.pend = 1'b0;
        end
        c_d.link_act_n = ~LINK_UP | (c_d.st == LGSD_ST_DARK);
        if (SRST) begin
            c_d            = '0;
            c_d.st         = LGSD_ST_STEADY;
            c_d.speed_n    = 1'b1;
            c_d.link_act_n = 1'b1;
            c_d.duplex_n   = 1'b1;
        end
    end

    // Core state register
    always_ff @(posedge CLK) begin
        c_q <= c_d;
    end

    // Map indicators onto their pins
    always_comb begin
        led_n                   = '1;
        led_n[`LGSD_PIN_SPEED]  = c_q.speed_n;
        led_n[`LGSD_PIN_LINK]   = c_q.link_act_n;
        led_n[`LGSD_PIN_DUPLEX] = c_q.duplex_n;
    end

    // One driver per pin; outputs are its flip-flops
    genvar gi;
    generate
        for (gi = 0; gi < `LGSD_NPINS; gi++) begin : g_pin
            lgsd_pin u_pin (
                .clk    (CLK),
                .srst   (SRST),
                .mode   (PIN_MODE[gi]),
                .dout   (GPIO_DOUT[gi]),
                .led_n  (led_n[gi]),
                .pin_i  (PIN_I[gi]),
                .pin_o  (PIN_O[gi]),
                .pin_oe (PIN_OE[gi]),
                .din    (GPIO_DIN[gi])
            );
        end
    endgenerate

    // Checks; each looks at registered state, so it sees
    // the effect one edge after the inputs that caused it
    property p_push_drive;
        @(posedge CLK) disable iff (SRST)
        PIN_MODE[0] == LGSD_MODE_PUSH |=> PIN_OE[0] && PIN_O[0] == $past(GPIO_DOUT[0]);
    endproperty
    a_push_drive: assert property (p_push_drive) else $error("push-pull pin not driven");

    property p_led_odrain;
        @(posedge CLK) disable iff (SRST)
        PIN_MODE[1] == LGSD_MODE_LED |=> !PIN_O[1] && (PIN_OE[1] == !$past(c_q.link_act_n));
    endproperty
    a_led_odrain: assert property (p_led_odrain) else $error("indicator pin not open-drain");

    property p_speed_on;
        @(posedge CLK) disable iff (SRST)
        LINK_UP && SPEED_100 && !AN_BUSY |=> !c_q.speed_n;
    endproperty
    a_speed_on: assert property (p_speed_on) else $error("speed indicator not lit");

    property p_speed_off;
        @(posedge CLK) disable iff (SRST)
        !LINK_UP || !SPEED_100 || AN_BUSY |=> c_q.speed_n;
    endproperty
    a_speed_off: assert property (p_speed_off) else $error("speed indicator lit wrongly");

    property p_link_lit;
        @(posedge CLK) disable iff (SRST)
        LINK_UP && c_q.st == LGSD_ST_STEADY && !ACTIVITY && !c_q.pend ##1 LINK_UP
        |-> !c_q.link_act_n;
    endproperty
    a_link_lit: assert property (p_link_lit) else $error("link indicator not lit");

    property p_dark_len;
        @(posedge CLK) disable iff (SRST)
        // Link loss or reset also ends a pulse early; only a natural end counts
        $fell(c_q.st == LGSD_ST_DARK) && $past(LINK_UP) && !$past(SRST)
        |-> $past(c_q.cnt) == BLINK_LAST;
    endproperty
    a_dark_len: assert property (p_dark_len) else $error("unlit pulse wrong length");

    property p_lit_min;
        @(posedge CLK) disable iff (SRST)
        $rose(c_q.st == LGSD_ST_DARK) && $past(c_q.st) == LGSD_ST_LIT
        |-> $past(c_q.cnt) == BLINK_LAST;
    endproperty
    a_lit_min: assert property (p_lit_min) else $error("lit gap too short");

    property p_duplex;
        @(posedge CLK) disable iff (SRST)
        1'b1 |=> c_q.duplex_n == !($past(LINK_UP) && $past(FULL_DUPLEX));
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex indicator wrong");

    property p_latch;
        @(posedge CLK) disable iff (SRST)
        LINK_UP && ACTIVITY && c_q.st == LGSD_ST_DARK && !phase_end ##1 LINK_UP |-> c_q.pend;
    endproperty
    a_latch: assert property (p_latch) else $error("activity not latched");

    property p_nolink;
        @(posedge CLK) disable iff (SRST)
        !LINK_UP |=> c_q.link_act_n && c_q.st == LGSD_ST_STEADY && !c_q.pend;
    endproperty
    a_nolink: assert property (p_nolink) else $error("blink without link");

    property p_count;
        @(posedge CLK) disable iff (SRST)
        LINK_UP && c_q.st == LGSD_ST_DARK && !phase_end ##1 LINK_UP
        |-> c_q.cnt == $past(c_q.cnt) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("phase counter stalled");

    property p_reset;
        @(posedge CLK)
        SRST |=> PIN_OE == '0 && c_q.st == LGSD_ST_STEADY && c_q.cnt == '0 && c_q.link_act_n;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    // Scenarios worth seeing: first blink, repeat, link loss, GPIO drive
    c_blink: cover property (@(posedge CLK) disable iff (SRST)
        $rose(c_q.st == LGSD_ST_DARK));
    c_repeat: cover property (@(posedge CLK) disable iff (SRST)
        c_q.st == LGSD_ST_LIT ##1 c_q.st == LGSD_ST_DARK);
    c_drop: cover property (@(posedge CLK) disable iff (SRST)
        c_q.st == LGSD_ST_DARK ##1 !LINK_UP);
    c_push: cover property (@(posedge CLK) disable iff (SRST)
        PIN_MODE[0] == LGSD_MODE_PUSH ##1 PIN_OE[0]);

endmodule

// *** design/lgsd_params.svh ***
`ifndef LGSD_PARAMS_SVH
`define LGSD_PARAMS_SVH

// Reference clock rate in hertz
`define LGSD_CLK_HZ      10000000
// Length of each blink phase, in milliseconds
`define LGSD_BLINK_MS    80
// Cycles in one blink phase, derived from the two figures above
`define LGSD_BLINK_CYC   (`LGSD_BLINK_MS * (`LGSD_CLK_HZ / 1000))
// Width of the blink phase counter
`define LGSD_CNT_W       20
// Number of multipurpose pins
`define LGSD_NPINS       3
// Pin positions of the three indicators
`define LGSD_PIN_SPEED   0
`define LGSD_PIN_LINK    1
`define LGSD_PIN_DUPLEX  2

`endif

// *** design/lgsd_pkg.sv ***
package lgsd_pkg;

    // Function of one multipurpose pin
    typedef enum logic [1:0] {
        LGSD_MODE_INPUT  = 2'h0,
        LGSD_MODE_PUSH   = 2'h1,
        LGSD_MODE_ODRAIN = 2'h2,
        LGSD_MODE_LED    = 2'h3
    } lgsd_mode_e;

    // Blink sequencer states, one-hot
    typedef enum logic [2:0] {
        LGSD_ST_STEADY = 3'b001,
        LGSD_ST_DARK   = 3'b010,
        LGSD_ST_LIT    = 3'b100
    } lgsd_state_e;

    // State of one pin driver
    typedef struct packed {
        logic o;
        logic oe;
        logic rd;
    } lgsd_pin_s;

    // State of the indicator core
    typedef struct packed {
        lgsd_state_e     st;
        logic [19:0]     cnt;
        logic            pend;
        logic            speed_n;
        logic            link_act_n;
        logic            duplex_n;
    } lgsd_core_s;

endpackage

// *** design/lgsd_pin.sv ***
`timescale 1ns/100ps

// One multipurpose pin: GPIO or open-drain indicator
module lgsd_pin (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire lgsd_pkg::lgsd_mode_e mode,
    input  wire logic                dout,
    input  wire logic                led_n,
    input  wire logic                pin_i,
    output logic                     pin_o,
    output logic                     pin_oe,
    output logic                     din
);
    import lgsd_pkg::*;

    lgsd_pin_s s_q;  // Registered pin state
    lgsd_pin_s s_d;  // Next pin state

    // Next state of the pin drivers
    always_comb begin
        s_d    = s_q;
        s_d.rd = pin_i;  // Input sampled in every mode
        case (mode)
            LGSD_MODE_PUSH: begin
                s_d.o  = dout;
                s_d.oe = 1'b1;
            end
            LGSD_MODE_ODRAIN: begin
                s_d.o  = 1'b0;
                s_d.oe = ~dout;
            end
            LGSD_MODE_LED: begin
                // Indicator only pulls low, never drives high
                s_d.o  = 1'b0;
                s_d.oe = ~led_n;
            end
            default: begin
                s_d.o  = 1'b0;
                s_d.oe = 1'b0;
            end
        endcase
        if (srst) begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign pin_o  = s_q.o;
    assign pin_oe = s_q.oe;
    assign din    = s_q.rd;

endmodule

// *** tb/lgsd_board.sv ***
`timescale 1ns/100ps

// Board side: pull-ups and a driver for pins set as inputs
module lgsd_board (
    input  wire logic [2:0] pin_o,  // Device value
    input  wire logic [2:0] pin_oe, // Device drives
    input  wire logic [2:0] ext_o,  // Board value
    input  wire logic [2:0] ext_oe, // Board drives
    output logic      [2:0] pin_i   // Pad level
);
    // A fight at opposite levels reads unknown so a level clash is never hidden
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i] && ext_oe[i] && pin_o[i] != ext_o[i])
                pin_i[i] = 1'bx;
            else if (pin_oe[i])
                pin_i[i] = pin_o[i];
            else if (ext_oe[i])
                pin_i[i] = ext_o[i];
            else
                pin_i[i] = 1'b1; // Pull-up
        end
    end
endmodule

// *** tb/tb_led_gpio_status_driver.sv ***
`timescale 1ns/100ps

module tb_led_gpio_status_driver;
    import lgsd_pkg::*;
    localparam int B = 4;    // Short blink phase
    logic clk, srst, chk_en; // Clock, reset, compare enable
    logic link_up, speed_100, an_busy, full_duplex, activity;
    lgsd_mode_e [2:0] mode;  // Pin functions
    logic [2:0] dout, ext_o, ext_oe, pin_o, pin_oe, pin_i, din;
    logic [2:0] ind_q, e_o, e_oe, e_din; // Expected state
    logic pend;              // Expected pending blink
    int st, ns, cnt;         // Expected phase: 0 steady, 1 dark, 2 lit
    int error_cnt = 0;
    int check_count = 0;

    always #50 clk = ~clk;

    lgsd_top #(.BLINK_CYCLES(B)) DUT (.CLK(clk), .SRST(srst), .LINK_UP(link_up),
        .SPEED_100(speed_100), .AN_BUSY(an_busy), .FULL_DUPLEX(full_duplex),
        .ACTIVITY(activity), .PIN_MODE(mode), .GPIO_DOUT(dout), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE(pin_oe), .GPIO_DIN(din));
    lgsd_board board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_o(ext_o),
        .ext_oe(ext_oe), .pin_i(pin_i));

    // Next blink phase: 0 steady, 1 dark, 2 lit
    function automatic int next_phase(input int s, input int c, input logic p,
                                      input logic lk, input logic a);
        if (!lk)
            return 0;
        if (s == 0)
            return a ? 1 : 0;
        if (c != B - 1)
            return s;
        if (s == 1)
            return 2;
        return (p || a) ? 1 : 0;
    endfunction

    // Expected output enable of one pin
    function automatic logic exp_oe(input lgsd_mode_e m, input logic d, input logic ind_n);
        case (m)
            LGSD_MODE_INPUT: return 1'b0;
            LGSD_MODE_PUSH: return 1'b1;
            LGSD_MODE_ODRAIN: return ~d;
            default: return ~ind_n;
        endcase
    endfunction

    // Expected pins: indicators one stage, pin drivers a second
    always @(posedge clk) begin
        if (srst) begin
            st <= 0;
            cnt <= 0;
            pend <= 1'b0;
            ind_q <= 3'h7;
            e_o <= 3'h0;
            e_oe <= 3'h0;
            e_din <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                e_o[i] <= (mode[i] == LGSD_MODE_PUSH) & dout[i];
                e_oe[i] <= exp_oe(mode[i], dout[i], ind_q[i]);
                // Pad worked out from the model, so a clash on the board shows up
                e_din[i] <= e_oe[i] ? e_o[i] : (ext_oe[i] ? ext_o[i] : 1'b1);
            end
            ind_q[0] <= ~(link_up & speed_100 & ~an_busy);
            ind_q[2] <= ~(link_up & full_duplex);
            // Blink phases; activity while blinking asks for one more
            ns = next_phase(st, cnt, pend, link_up, activity);
            cnt <= (ns != st || cnt == B - 1) ? 0 : cnt + 1;
            if (!link_up || (st == 2 && ns != 2))
                pend <= 1'b0;
            else if (st != 0 && activity)
                pend <= 1'b1;
            ind_q[1] <= !(link_up && ns != 1);
            st <= ns;
        end
    end

    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Outputs settle after the rising edge, so compare on the falling one
    always @(negedge clk) begin
        if (chk_en) begin
            check("pin_o", pin_o, e_o);
            check("oe_speed", 3'(pin_oe[0]), 3'(e_oe[0]));
            check("oe_link", 3'(pin_oe[1]), 3'(e_oe[1]));
            check("oe_duplex", 3'(pin_oe[2]), 3'(e_oe[2]));
            check("gpio_din", din, e_din);
        end
    end

    // Random inputs each falling edge within a mode range
    task automatic run(input string name, input int lo, input int hi,
                       input int act, input int drop, input int n);
        lgsd_mode_e m; // Newly drawn pin function
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            for (int i = 0; i < 3; i++) begin
                m = lgsd_mode_e'($urandom_range(hi, lo));
                // Board drives only once the pin has been an input for a whole cycle, half a cycle after the device lets go
                ext_oe[i] = (mode[i] == LGSD_MODE_INPUT) && (m == LGSD_MODE_INPUT);
                mode[i] = m;
            end
            dout = 3'($urandom);
            ext_o = 3'($urandom);
            link_up = ($urandom_range(99, 0) >= drop);
            speed_100 = 1'($urandom);
            an_busy = ($urandom_range(3, 0) == 0);
            full_duplex = 1'($urandom);
            activity = ($urandom_range(99, 0) < act);
        end
        $display("test %s done", name);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #2000000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        chk_en = 1'b0;
        {link_up, speed_100, an_busy, full_duplex, activity} = 5'h00;
        foreach (mode[i])
            mode[i] = LGSD_MODE_INPUT;
        {dout, ext_o, ext_oe} = 9'h000;
        void'($urandom(74767));
        @(negedge clk);
        chk_en = 1'b1; // Reset values checked too
        @(negedge clk);
        srst = 1'b0;
        run("gpio", 0, 2, 0, 0, 200);
        run("indicator", 3, 3, 8, 3, 400);
        run("busy", 3, 3, 100, 0, 30);
        @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        run("after_reset", 3, 3, 100, 1, 30);
        run("mixed", 0, 3, 20, 2, 400);
        give_verdict();
    end
endmodule
